// file: include/ppc_pkg.sv
package ppc_pkg;
    localparam int PPC_P0_PINS = 8;
    localparam int PPC_P1_PINS = 7;
    localparam int PPC_XB_PINS = 15;
    localparam logic [7:0] PPC_ADDR_P2_LATCH = 8'hA0;
    localparam logic [7:0] PPC_ADDR_P0_OTYPE = 8'hA4;
    localparam logic [7:0] PPC_ADDR_P1_DRV = 8'hA5;
    localparam logic [7:0] PPC_ADDR_P0_AIN = 8'hF1;
    localparam logic [3:0] PPC_PAGE_CFG = 4'h0;
    localparam logic [3:0] PPC_PAGE_DRV = 4'hF;
    localparam logic [7:0] PPC_RST_P2_LATCH = 8'h80;
    localparam logic [7:0] PPC_RST_P0_OTYPE = 8'h00;
    localparam logic [6:0] PPC_RST_P1_DRV = 7'h00;
    localparam logic [7:0] PPC_RST_P0_AIN = 8'hFF;
    localparam logic [6:0] PPC_RST_P0_DRV = 7'h00;
    localparam int PPC_P2_BIT = 7;
endpackage

// file: rtl/ppc_port_config.sv
`timescale 1ns/1ps
// Behaviour
// - Pins of port 0 and port 1 bits 0..6 serve analog, digital or interrupt use.
// - A pin with its skip bit set is never granted to the crossbar.
// - Input-mode bit 0 disables pull-up and receiver; resets to all ones.
// - Analog mode leaves the output driver alone.
// - Output-mode bit 0 open-drain, 1 push-pull, even in analog mode; resets zero.
// - Drivers reset to low strength; high strength selectable per pin.
// - Port 1 drive-strength bits 6..0 pick low or high drive per pin.
// - Port 1 drive-strength bit 7 reads zero and ignores writes.
// - Port 1 drive-strength register only on page 0xF at address 0xA5.
// - Port 2 bit 7 write sets latch; read returns the pin level.
// - Port 2 bits 6..0 read zero and ignore writes.
// - Port 2 data reachable from every page at 0xA0, bit-addressable.
module ppc_port_config
    import ppc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    input wire logic [ppc_pkg::PPC_XB_PINS-1:0] port_latch,
    input wire logic [ppc_pkg::PPC_XB_PINS-1:0] crossbar_exclude_bits,
    input wire logic [ppc_pkg::PPC_XB_PINS-1:0] xbar_req,
    input wire logic [ppc_pkg::PPC_XB_PINS-1:0] xbar_data,
    input wire logic [ppc_pkg::PPC_P1_PINS-1:0] port1_output_type,
    input wire logic [ppc_pkg::PPC_P0_PINS-1:0] port0_drive_strength_bits,
    input wire logic [ppc_pkg::PPC_XB_PINS-1:0] pin_in,
    input wire logic pin2_in,
    output logic [ppc_pkg::PPC_XB_PINS-1:0] pin_out,
    output logic [ppc_pkg::PPC_XB_PINS-1:0] pin_oe,
    output logic [ppc_pkg::PPC_XB_PINS-1:0] pin_high_drive,
    output logic [ppc_pkg::PPC_P0_PINS-1:0] pin_pullup_en,
    output logic [ppc_pkg::PPC_P0_PINS-1:0] pin_rx_en,
    output logic [ppc_pkg::PPC_XB_PINS-1:0] xbar_grant,
    output logic [ppc_pkg::PPC_XB_PINS-1:0] analog_avail,
    output logic [ppc_pkg::PPC_XB_PINS-1:0] digital_in,
    output logic pin2_out,
    output logic pin2_oe
);
    import ppc_pkg::*;

    logic [7:0] p0_otype_reg;
    logic [7:0] p0_ain_reg;
    logic [6:0] p1_drv_reg;
    logic p2_latch_reg;
    logic [7:0] rdata_reg;
    logic [PPC_XB_PINS-1:0] sync1_reg;
    logic [PPC_XB_PINS-1:0] sync2_reg;
    logic p2_sync1_reg;
    logic p2_sync2_reg;
    logic [PPC_XB_PINS-1:0] out_reg;
    logic [PPC_XB_PINS-1:0] oe_reg;
    logic [PPC_XB_PINS-1:0] drv_reg;
    logic [PPC_XB_PINS-1:0] grant_reg;
    logic [PPC_XB_PINS-1:0] avail_reg;
    logic [PPC_XB_PINS-1:0] din_reg;
    logic [7:0] pu_reg;
    logic p2_out_reg;
    logic p2_oe_reg;

    function automatic logic hit(input logic [7:0] a, input logic [3:0] pg,
                                 input logic [7:0] ra, input logic [3:0] rp, input logic any);
        hit = (a == ra) && (any || pg == rp);
    endfunction

    wire logic sel_otype = hit(sfr_addr, sfr_page, PPC_ADDR_P0_OTYPE, PPC_PAGE_CFG, 1'b0);
    wire logic sel_ain = hit(sfr_addr, sfr_page, PPC_ADDR_P0_AIN, PPC_PAGE_CFG, 1'b0);
    wire logic sel_drv = hit(sfr_addr, sfr_page, PPC_ADDR_P1_DRV, PPC_PAGE_DRV, 1'b0);
    wire logic sel_p2 = hit(sfr_addr, sfr_page, PPC_ADDR_P2_LATCH, PPC_PAGE_CFG, 1'b1);
    // Bit writes other than bit 7 land on unused bits and are dropped.
    wire logic p2_bit_hit = bit_wr && sel_p2 && bit_sel == 3'(PPC_P2_BIT);
    wire logic [7:0] rd_mux = sel_otype ? p0_otype_reg :
                              sel_ain ? p0_ain_reg :
                              sel_drv ? {1'b0, p1_drv_reg} :
                              sel_p2 ? {p2_sync2_reg, 7'h00} : 8'h00;

    // Per-pin wiring: port 0 has its own type bits, port 1 takes them from outside.
    wire logic [PPC_XB_PINS-1:0] otype = {port1_output_type, p0_otype_reg};
    wire logic [PPC_XB_PINS-1:0] hdrv = {p1_drv_reg, port0_drive_strength_bits};
    wire logic [PPC_XB_PINS-1:0] ain = {{PPC_P1_PINS{1'b1}}, p0_ain_reg};
    wire logic [PPC_XB_PINS-1:0] grant;
    wire logic [PPC_XB_PINS-1:0] val;
    wire logic [PPC_XB_PINS-1:0] oe;

    // Analog select is deliberately absent here; software must park the driver itself.
    genvar g;
    generate
        for (g = 0; g < PPC_XB_PINS; g = g + 1) begin : g_pin
            assign grant[g] = xbar_req[g] && !crossbar_exclude_bits[g];
            assign val[g] = grant[g] ? xbar_data[g] : port_latch[g];
            assign oe[g] = otype[g] || !val[g];
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p0_otype_reg <= PPC_RST_P0_OTYPE;
        end else if (sfr_wr && sel_otype) begin
            p0_otype_reg <= sfr_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p0_ain_reg <= PPC_RST_P0_AIN;
        end else if (sfr_wr && sel_ain) begin
            p0_ain_reg <= sfr_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p1_drv_reg <= PPC_RST_P1_DRV;
        end else if (sfr_wr && sel_drv) begin
            p1_drv_reg <= sfr_wdata[6:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p2_latch_reg <= PPC_RST_P2_LATCH[PPC_P2_BIT];
        end else begin
            if (sfr_wr && sel_p2) begin
                p2_latch_reg <= sfr_wdata[PPC_P2_BIT];
            end else if (p2_bit_hit) begin
                p2_latch_reg <= bit_val;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            p2_sync1_reg <= 1'b0;
            p2_sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            p2_sync1_reg <= pin2_in;
            p2_sync2_reg <= p2_sync1_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= sfr_rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg <= '1;
            oe_reg <= '0;
            drv_reg <= '0;
        end else begin
            out_reg <= val;
            oe_reg <= oe;
            drv_reg <= hdrv;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            grant_reg <= '0;
            avail_reg <= '0;
        end else begin
            grant_reg <= grant;
            avail_reg <= crossbar_exclude_bits;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            din_reg <= '0;
            pu_reg <= '1;
        end else begin
            din_reg <= sync2_reg & ain;
            pu_reg <= p0_ain_reg;
        end
    end

    // Port 2 is open-drain only, so a high latch releases the pin to its pull-up.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p2_out_reg <= 1'b1;
            p2_oe_reg <= 1'b0;
        end else begin
            p2_out_reg <= p2_latch_reg;
            p2_oe_reg <= ~p2_latch_reg;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign pin_out = out_reg;
    assign pin_oe = oe_reg;
    assign pin_high_drive = drv_reg;
    assign pin_pullup_en = pu_reg;
    assign pin_rx_en = pu_reg;
    assign xbar_grant = grant_reg;
    assign analog_avail = avail_reg;
    assign digital_in = din_reg;
    assign pin2_out = p2_out_reg;
    assign pin2_oe = p2_oe_reg;
endmodule // ppc_port_config

// file: verification/ppc_pin_model.sv
`timescale 1ns/1ps
// Pull-ups lift every released line, so no stale driven level survives.
module ppc_pin_model import ppc_pkg::*; (
    input wire logic [14:0] pin_out,
    input wire logic [14:0] pin_oe,
    input wire logic pin2_out,
    input wire logic pin2_oe,
    output logic [14:0] pin_in,
    output logic pin2_in);
    assign pin_in = pin_out | ~pin_oe;
    assign pin2_in = pin2_out | !pin2_oe;
endmodule // ppc_pin_model

// file: verification/ppc_port_config_properties.sv
`timescale 1ns/1ps
module ppc_chk import ppc_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] pin_pullup_en,
    input wire logic [7:0] pin_rx_en);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    idle_zero_a: assert property (!sfr_rd |=> !sfr_rdata) else $error("idle");
    drv_top_a: assert property (sfr_rd && sfr_addr == 8'hA5 |=> !sfr_rdata[7]) else $error("b7");
    p2_low_a: assert property (sfr_rd && sfr_addr == 8'hA0 |=> !sfr_rdata[6:0]) else $error("p2");
    drv_page_a: assert property (sfr_rd && sfr_addr == 8'hA5 ##0 sfr_page != 4'hF
        |=> !sfr_rdata) else $error("page");
    ain_page_a: assert property (sfr_rd && sfr_addr == 8'hF1 ##0 sfr_page != 4'h0
        |=> !sfr_rdata) else $error("page");
    otype_page_a: assert property (sfr_rd && sfr_addr == 8'hA4 ##0 sfr_page != 4'h0
        |=> !sfr_rdata) else $error("page");
    pull_rx_a: assert property (pin_pullup_en == pin_rx_en) else $error("rx");
    // Covers write latencies of one or two edges.
    pull_hold_a: assert property (!$past(sfr_wr) && !$past(sfr_wr, 2) |-> $stable(pin_pullup_en))
        else $error("hold");
endmodule // ppc_chk
bind ppc_port_config ppc_chk u_ppc_chk(.clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_rdata, .pin_pullup_en, .pin_rx_en);

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ppc_pkg::*;
    logic clk = 1'h0, rst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0, bit_wr = 1'h0, bit_val = 1'h1;
    logic pin2_in, pin2_out, pin2_oe;
    logic [2:0] bit_sel = 3'h7;
    logic [3:0] sfr_page = 4'h0;
    logic [6:0] port1_output_type = 7'h00;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, port0_drive_strength_bits = 8'h55;
    logic [7:0] sfr_rdata, pin_pullup_en, pin_rx_en;
    logic [14:0] port_latch = 15'h7FFF, crossbar_exclude_bits = 15'h0000, xbar_req = 15'h0000;
    logic [14:0] xbar_data = 15'h0000, pin_in, pin_out, pin_oe, pin_high_drive, xbar_grant;
    logic [14:0] analog_avail, digital_in;
    int err_total = 0, comparisons = 0;
    always #2 clk = ~clk;
    ppc_port_config u_ppc_port_config(.clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_wdata,
        .sfr_rd, .sfr_rdata, .bit_wr, .bit_sel, .bit_val, .port_latch, .crossbar_exclude_bits,
        .xbar_req, .xbar_data, .port1_output_type, .port0_drive_strength_bits, .pin_in, .pin2_in,
        .pin_out, .pin_oe, .pin_high_drive, .pin_pullup_en, .pin_rx_en, .xbar_grant,
        .analog_avail, .digital_in, .pin2_out, .pin2_oe);
    ppc_pin_model u_ppc_pin_model(.pin_out, .pin_oe, .pin2_out, .pin2_oe, .pin_in, .pin2_in);
    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        comparisons++;
        err_total += int'(seen !== exp);
        if (seen !== exp) $display("ERROR %0t %h %h", $time, seen, exp);
    endtask
    task automatic xfer(input logic w, input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1 {sfr_wr, sfr_rd, sfr_page, sfr_addr, sfr_wdata} = {w, !w, p, a, d};
        @(posedge clk) #1 {sfr_wr, sfr_rd} = 2'h0;
        if (!w) chk(15'(sfr_rdata), 15'(d));
    endtask
    task automatic t_regs();
        xfer(1'h0, 4'h3, 8'hF1, 8'h00);
        xfer(1'h0, 4'h0, 8'hF1, 8'hFF);
        xfer(1'h0, 4'h3, 8'hA4, 8'h00);
        xfer(1'h1, 4'hF, 8'hA5, 8'hFF);
        xfer(1'h0, 4'hF, 8'hA5, 8'h7F);
        xfer(1'h0, 4'h0, 8'hA5, 8'h00);
        xfer(1'h1, 4'h0, 8'hF1, 8'h00);
        xfer(1'h1, 4'h0, 8'hA4, 8'hFF);
        #40 chk(15'({pin_oe[7:0], pin_pullup_en[6:0]}), 15'h7F80);
    endtask
    task automatic t_pins();
        xfer(1'h1, 4'h5, 8'hA0, 8'h7F);
        #40 xfer(1'h0, 4'h9, 8'hA0, 8'h00);
        {crossbar_exclude_bits, xbar_req, xbar_data, bit_wr} = {15'h00F0, 15'h7FFF, 15'h7FFF, 1'h1};
        #4 bit_wr = 1'h0;
        #40 chk(xbar_grant, 15'h7F0F);
        xfer(1'h0, 4'h2, 8'hA0, 8'h80);
        #40 chk(pin_high_drive, 15'h7F55);
        chk(digital_in, 15'h7F00);
        chk(pin_out, 15'h7FFF);
        chk(15'({pin2_out, pin2_oe}), 15'h0002);
        xfer(1'h1, 4'h0, 8'hA4, 8'h00);
        #40 chk(pin_oe, 15'h0000);
        chk(analog_avail, 15'h00F0);
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #4000 err_total++;
        summarize();
    end
    initial begin
        #79 rst = 1'h0;
        t_regs();
        t_pins();
        summarize();
    end
endmodule // tb_top
